// ===== rtl/pull_bank_pkg.sv
/*
  constants, field layout and reset values of the oscillator pull register
  bank, plus the pull-range span lookup.
  assumes nothing of its surroundings; used by scoped name only.
*/
package pull_bank_pkg;

  // register addresses as seen by the serial register engine
  localparam logic [7:0] ADDR_LOW = 8'h00;
  localparam logic [7:0] ADDR_HIGH = 8'h01;
  localparam logic [7:0] ADDR_RANGE = 8'h02;

  // field widths and positions
  localparam int REG_W = 16;
  localparam int WORD_W = 26;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 10;
  localparam int OE_BIT = 10;
  localparam int RANGE_W = 4;
  localparam int SPAN_W = 14;
  localparam int NUM_W = WORD_W + SPAN_W + 1;
  localparam int BUNDLE_W = WORD_W + 1 + RANGE_W;

  // reset values
  localparam logic [LOW_W-1:0] LOW_RESET = 16'h0000;
  localparam logic [HIGH_W-1:0] HIGH_RESET = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 26'h0000000;
  localparam logic OE_RESET = 1'b0;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h0;

  // positive full-scale code, 2^25-1 = 33,554,431
  localparam logic [WORD_W-1:0] FULL_SCALE = 26'h1ffffff;

  // half pull span in quarter-ppm steps, code 0 narrowest .. 15 widest
  function automatic logic [SPAN_W-1:0] span_quarter_ppm(
    input logic [RANGE_W-1:0] code
  );
    logic [SPAN_W-1:0] s;
    s = 14'h0000;
    unique case (code)
      4'h0: s = 14'h0019; // 6.25 ppm
      4'h1: s = 14'h0028; // 10
      4'h2: s = 14'h0032; // 12.5
      4'h3: s = 14'h0064; // 25
      4'h4: s = 14'h00c8; // 50
      4'h5: s = 14'h0140; // 80
      4'h6: s = 14'h0190; // 100
      4'h7: s = 14'h01f4; // 125
      4'h8: s = 14'h0258; // 150
      4'h9: s = 14'h0320; // 200
      4'ha: s = 14'h0640; // 400
      4'hb: s = 14'h0960; // 600
      4'hc: s = 14'h0c80; // 800
      4'hd: s = 14'h12c0; // 1200
      4'he: s = 14'h1900; // 1600
      4'hf: s = 14'h3200; // 3200
    endcase
    return s;
  endfunction

endpackage

// ===== rtl/word_handshake_cdc.sv
/*
  moves one data word from a source clock domain to a destination domain
  with a toggle request and toggle acknowledge.
  assumes the source waits for busy low before the next send; the data is
  held in a source-side copy until acknowledged.
*/
`timescale 1ns/1ps

module word_handshake_cdc #(
  parameter int WIDTH = 31
) (
  // source domain
  input wire logic src_clk_in,
  input wire logic src_reset_in,
  input wire logic src_send_in,
  input wire logic [WIDTH-1:0] src_data_in,
  output logic src_busy_out,
  // destination domain
  input wire logic dst_clk_in,
  input wire logic dst_reset_in,
  output logic dst_valid_out,
  output logic [WIDTH-1:0] dst_data_out
);

  typedef struct packed {
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [WIDTH-1:0] data;
  } src_state_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic valid;
    logic [WIDTH-1:0] data;
  } dst_state_t;

  src_state_t src, next_src;
  dst_state_t dst, next_dst;

  // source: latch data and flip the request; ack comes back through 2 flops
  always_comb
  begin
    next_src = src;
    next_src.ack_s1 = dst.ack;
    next_src.ack_s2 = src.ack_s1;
    if (src_send_in && (src.req == src.ack_s2))
    begin
      next_src.req = ~src.req;
      next_src.data = src_data_in;
    end
  end

  always_ff @(posedge src_clk_in)
  begin
    if (src_reset_in)
      src <= '0;
    else
      src <= next_src;
  end

  assign src_busy_out = src.req != src.ack_s2;

  // destination: the source copy is stable while req and ack differ
  always_comb
  begin
    next_dst = dst;
    next_dst.req_s1 = src.req;
    next_dst.req_s2 = dst.req_s1;
    next_dst.valid = 1'b0;
    if (dst.req_s2 != dst.ack)
    begin
      next_dst.ack = dst.req_s2;
      next_dst.data = src.data;
      next_dst.valid = 1'b1;
    end
  end

  always_ff @(posedge dst_clk_in)
  begin
    if (dst_reset_in)
      dst <= '0;
    else
      dst <= next_dst;
  end

  assign dst_valid_out = dst.valid;
  assign dst_data_out = dst.data;

endmodule

// ===== rtl/frequency_pull_register_bank.sv
/*
  register bank of a digitally tuned oscillator: low and high halves of the
  signed pull control word, software output enable and pull range select,
  written by a serial register engine on the link clock, applied to the
  oscillator core on ref_clk_in.
  assumes the register engine gives one-cycle write and read strobes on the
  link clock and that the link clock may stop between frames.
*/
`timescale 1ns/1ps

module frequency_pull_register_bank (
  // core clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // link side register port
  input wire logic link_clk_in,
  input wire logic link_reset_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // output enable control strap, high selects software control
  input wire logic sw_oe_mode_in,
  // applied settings toward the oscillator core
  output logic [25:0] pull_control_word_out,
  output logic [3:0] pull_range_out,
  output logic [13:0] pull_span_out,
  output logic [40:0] pull_numerator_out,
  output logic sw_output_enable_out,
  output logic pull_update_out
);

  // link-domain state; mode_s1 feeds only mode_s2, the strap synchroniser
  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic [pull_bank_pkg::LOW_W-1:0] low_control_half;
    logic [pull_bank_pkg::HIGH_W-1:0] high_control_half;
    logic oe;
    logic [pull_bank_pkg::RANGE_W-1:0] range;
    logic [pull_bank_pkg::WORD_W-1:0] commit;
    logic pending;
    logic [pull_bank_pkg::REG_W-1:0] rdata;
    logic rvalid;
  } link_state_t;

  typedef struct packed {
    logic [pull_bank_pkg::WORD_W-1:0] word;
    logic [pull_bank_pkg::RANGE_W-1:0] range;
    logic [pull_bank_pkg::SPAN_W-1:0] span;
    logic [pull_bank_pkg::NUM_W-1:0] numerator;
    logic oe;
    logic update;
  } core_state_t;

  link_state_t lk, next_lk;
  core_state_t cr, next_cr;

  // handshake wires linking the crossing to the link register file and the core registers
  logic send;
  logic busy;
  logic [pull_bank_pkg::BUNDLE_W-1:0] bundle;
  logic arrived;
  logic [pull_bank_pkg::BUNDLE_W-1:0] arrived_bundle;

  // read mux; unused bits and unmapped addresses give zero
  function automatic logic [15:0] read_value(
    input link_state_t s,
    input logic [7:0] addr
  );
    logic [15:0] v;
    v = 16'h0000;
    if (addr == pull_bank_pkg::ADDR_LOW)
      v = s.low_control_half;
    else if (addr == pull_bank_pkg::ADDR_HIGH)
      v = {5'h00, s.oe, s.high_control_half};
    else if (addr == pull_bank_pkg::ADDR_RANGE)
      v = {12'h000, s.range};
    return v;
  endfunction

  // link domain: register file, commit on high write, queue a transfer
  always_comb
  begin
    next_lk = lk;
    next_lk.mode_s1 = sw_oe_mode_in;
    next_lk.mode_s2 = lk.mode_s1;
    next_lk.rvalid = reg_read_in;
    if (reg_read_in)
      next_lk.rdata = read_value(lk, reg_addr_in);
    // a transfer launched now clears pending; a new high or range write re-arms it
    if (send)
      next_lk.pending = 1'b0;
    if (reg_write_in)
    begin
      unique case (reg_addr_in)
        pull_bank_pkg::ADDR_LOW:
        begin
          // stored only; no frequency change from this write
          next_lk.low_control_half = reg_wdata_in;
        end
        pull_bank_pkg::ADDR_HIGH:
        begin
          next_lk.high_control_half =
            reg_wdata_in[pull_bank_pkg::HIGH_W-1:0];
          if (lk.mode_s2)
            next_lk.oe = reg_wdata_in[pull_bank_pkg::OE_BIT];
          // both halves taken in one step so no torn word is applied
          next_lk.commit = {reg_wdata_in[pull_bank_pkg::HIGH_W-1:0],
                            lk.low_control_half};
          next_lk.pending = 1'b1;
        end
        pull_bank_pkg::ADDR_RANGE:
        begin
          next_lk.range = reg_wdata_in[pull_bank_pkg::RANGE_W-1:0];
          next_lk.pending = 1'b1;
        end
        default:
        begin
          next_lk.pending = next_lk.pending; // unmapped write ignored
        end
      endcase
    end
  end

  // link registers; reset returns every field to its power-up value
  always_ff @(posedge link_clk_in)
  begin
    if (link_reset_in)
    begin
      lk <= '0;
      lk.low_control_half <= pull_bank_pkg::LOW_RESET;
      lk.high_control_half <= pull_bank_pkg::HIGH_RESET;
      lk.commit <= pull_bank_pkg::WORD_RESET;
      lk.oe <= pull_bank_pkg::OE_RESET;
      lk.range <= pull_bank_pkg::RANGE_RESET;
    end
    else
      lk <= next_lk;
  end

  // launch waits for the previous transfer; latest values win
  assign send = lk.pending && !busy;
  assign bundle = {lk.commit, lk.oe, lk.range};
  assign reg_rdata_out = lk.rdata;
  assign reg_rvalid_out = lk.rvalid;

  // committed settings cross by toggle handshake
  word_handshake_cdc #(
    .WIDTH(pull_bank_pkg::BUNDLE_W)
  ) crossing (
    .src_clk_in(link_clk_in),
    .src_reset_in(link_reset_in),
    .src_send_in(send),
    .src_data_in(bundle),
    .src_busy_out(busy),
    .dst_clk_in(ref_clk_in),
    .dst_reset_in(reset_in),
    .dst_valid_out(arrived),
    .dst_data_out(arrived_bundle)
  );

  // core domain: apply arrived settings, scale word against span
  always_comb
  begin
    next_cr = cr;
    next_cr.update = arrived;
    if (arrived)
    begin
      next_cr.word = arrived_bundle[pull_bank_pkg::BUNDLE_W-1 -:
                                    pull_bank_pkg::WORD_W];
      next_cr.oe = arrived_bundle[pull_bank_pkg::RANGE_W];
      next_cr.range = arrived_bundle[pull_bank_pkg::RANGE_W-1:0];
    end
    next_cr.span = pull_bank_pkg::span_quarter_ppm(cr.range);
    // signed word times span; divide by full scale downstream
    next_cr.numerator = pull_bank_pkg::NUM_W'($signed(cr.word) *
                        $signed({1'b0, cr.span}));
  end

  // core registers; span reset matches range code 0 so outputs agree
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      cr <= '0;
      cr.word <= pull_bank_pkg::WORD_RESET;
      cr.oe <= pull_bank_pkg::OE_RESET;
      cr.range <= pull_bank_pkg::RANGE_RESET;
      cr.span <= pull_bank_pkg::span_quarter_ppm(
                   pull_bank_pkg::RANGE_RESET);
    end
    else
      cr <= next_cr;
  end

  // applied settings come straight from flops, glitch free for the core
  assign pull_control_word_out = cr.word;
  assign pull_range_out = cr.range;
  assign pull_span_out = cr.span;
  assign pull_numerator_out = cr.numerator;
  assign sw_output_enable_out = cr.oe;
  assign pull_update_out = cr.update;

endmodule

// ===== dv/frequency_pull_register_bank_asserts.sv
/*
  checker for the pull register bank: read answers, spare bits, apply path.
  assumes it is bound to the bank top and sees only its ports.
*/
`timescale 1ns/1ps

module pull_bank_checker (
  // clocks and resets
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic link_reset_in,
  // register port
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // applied settings
  input wire logic [25:0] pull_control_word_out,
  input wire logic [3:0] pull_range_out,
  input wire logic [13:0] pull_span_out,
  input wire logic [40:0] pull_numerator_out,
  input wire logic sw_output_enable_out,
  input wire logic pull_update_out
);
  // link side: every read answered a cycle later
  a_read_answer: assert property (@(posedge link_clk_in)
    disable iff (link_reset_in) reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_high_spare_zero: assert property (@(posedge link_clk_in)
    disable iff (link_reset_in) reg_read_in && reg_addr_in == 8'h01
    |=> reg_rdata_out[15:11] == 5'h00) else $error("spare high bits");
  a_range_spare_zero: assert property (@(posedge link_clk_in)
    disable iff (link_reset_in) reg_read_in && reg_addr_in == 8'h02
    |=> reg_rdata_out[15:4] == 12'h000) else $error("spare range bits");
  // core side: word, oe and range move only with the update pulse, span one cycle after it
  a_word_needs_update: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) $changed(pull_control_word_out)
    |-> pull_update_out) else $error("word moved alone");
  a_oe_range_update: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) $changed(pull_range_out)
    || $changed(sw_output_enable_out) |-> pull_update_out)
    else $error("oe or range moved alone");
  a_span_after_update: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) $changed(pull_span_out)
    |-> $past(pull_update_out)) else $error("span moved late");
  // signed word times span, two cycles after the pulse
  a_numer_product: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) pull_update_out |=> ##1
    $signed(pull_numerator_out) == $signed(pull_control_word_out)
    * $signed({1'b0, pull_span_out})) else $error("bad numerator");
  a_reset_values: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) $fell(reset_in)
    |-> pull_control_word_out == 26'h0000000 && !sw_output_enable_out)
    else $error("bad reset values");
endmodule

bind frequency_pull_register_bank pull_bank_checker chk_i (
  .ref_clk_in, .reset_in, .link_clk_in, .link_reset_in, .reg_read_in,
  .reg_addr_in, .reg_rdata_out, .reg_rvalid_out, .pull_control_word_out,
  .pull_range_out, .pull_span_out, .pull_numerator_out,
  .sw_output_enable_out, .pull_update_out
);

// ===== dv/link_host_model.sv
/*
  link-side host: register writes and reads with a link clock that stands
  high between frames. assumes the bank's link register port.
*/
`timescale 1ns/1ps

module link_host_model (
  // link clock and reset
  output logic link_clk_out,
  output logic link_reset_out,
  // register port
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [7:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  input wire logic [15:0] reg_rdata_in
);
  // idle levels at time zero
  initial
  begin
    link_clk_out = 1'b1;
    link_reset_out = 1'b1;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
  end
  // n link cycles of 48 ns, ending just after a rising edge
  task automatic tick(input int n);
    repeat (n)
    begin
      #24 link_clk_out = 1'b0;
      #24 link_clk_out = 1'b1;
    end
  endtask
  task automatic rst();
    tick(3);
    link_reset_out <= 1'b0;
    tick(2);
  endtask
  // trailing cycles keep the clock running for the crossing acknowledge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_write_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    tick(1);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
    tick(5);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    reg_read_out <= 1'b1;
    reg_addr_out <= a;
    tick(1);
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    tick(1);
    // rdata was launched an edge earlier and holds until the next read
    q = reg_rdata_in;
  endtask
  // low half first, then high half, then the update-rate gap
  task automatic upd(input logic [15:0] lo, input logic [15:0] hi);
    wr(8'h00, lo);
    wr(8'h01, hi);
    #26400;
  endtask
endmodule

// ===== dv/frequency_pull_register_bank_tb_top.sv
/*
  self-checking bench of the pull register bank with a link host model.
  assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps

module frequency_pull_register_bank_tb_top;
  logic ref_clk_in, reset_in, sw_oe_mode_in, lclk, lrst, wr_s, rd_s;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [25:0] word;
  logic [3:0] range;
  logic [13:0] span;
  logic oe, upd, eoe;
  logic [31:0] seed = 32'h0000ce19;
  logic [31:0] r;
  logic [31:0] corner [3] = '{32'h81ffffff, 32'h02000000, 32'h07ffffff};
  int error_cnt, n_checks, n_upd, n0;

  frequency_pull_register_bank dut (.ref_clk_in, .reset_in,
    .link_clk_in(lclk), .link_reset_in(lrst), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(), .sw_oe_mode_in,
    .pull_control_word_out(word), .pull_range_out(range),
    .pull_span_out(span), .pull_numerator_out(),
    .sw_output_enable_out(oe), .pull_update_out(upd));
  link_host_model host (.link_clk_out(lclk), .link_reset_out(lrst),
    .reg_write_out(wr_s), .reg_read_out(rd_s), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata));

  // half pull span per range code in quarter ppm, 6.25 up to 3200 ppm
  localparam logic [13:0] SPAN_Q [16] = '{
    14'h0019, 14'h0028, 14'h0032, 14'h0064,
    14'h00c8, 14'h0140, 14'h0190, 14'h01f4,
    14'h0258, 14'h0320, 14'h0640, 14'h0960,
    14'h0c80, 14'h12c0, 14'h1900, 14'h3200};

  function automatic logic [13:0] exp_span(input logic [3:0] c);
    return SPAN_Q[c];
  endfunction
  function automatic logic [31:0] rand_word();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // clock, update counter and watchdog
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
    if (upd === 1'b1)
      n_upd++;
  initial
  begin
    #950000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    reset_in = 1'b1;
    sw_oe_mode_in = 1'b1;
    eoe = 1'b0;
    fork
      host.rst();
      begin
        repeat (6) @(posedge ref_clk_in);
        reset_in <= 1'b0;
      end
    join
    for (int i = 0; i < 4; i++)
    begin
      host.rd(i[7:0] + 8'h05 * i[7:0] / 3, q);
      chk(q, 0);
    end
    chk({word, oe}, 0);
    $display("test reset done");
    n0 = n_upd;
    host.wr(8'h00, 16'h1234);
    host.rd(8'h00, q);
    chk(q, 16'h1234);
    chk(n_upd - n0, 0);
    host.upd(16'h1234, 16'hffff);
    host.rd(8'h01, q);
    chk(q, 16'h07ff);
    chk(word, 26'h3ff1234);
    eoe = 1'b1;
    chk(oe, eoe);
    $display("test halves done");
    for (int i = 0; i < 10; i++)
    begin
      r = (i < 3) ? corner[i] : rand_word();
      @(posedge ref_clk_in);
      sw_oe_mode_in <= r[31];
      n0 = n_upd;
      host.upd(r[15:0], {5'h00, r[26], r[25:16]});
      eoe = r[31] ? r[26] : eoe;
      chk(n_upd - n0, 1);
      chk(word, r[25:0]);
      chk(oe, eoe);
    end
    $display("test words done");
    for (int c = 0; c < 16; c++)
    begin
      host.wr(8'h02, 16'hfff0 | c[15:0]);
      #26400;
      chk(range, c);
      host.rd(8'h02, q);
      chk(q, c);
      chk(span, exp_span(c[3:0]));
    end
    $display("test ranges done");
    end_sim();
  end
endmodule
